// *** hw/conv_ctrl_pkg.sv ***
package conv_ctrl_pkg;

    // =====================================================================
    // register byte addresses
    localparam logic [7:0] ADDR_INPUT_SELECT = 8'h00;
    localparam logic [7:0] ADDR_CTRL_A       = 8'h04;
    localparam logic [7:0] ADDR_CTRL_B       = 8'h08;
    localparam logic [7:0] ADDR_RESULT_LOW   = 8'h0C;
    localparam logic [7:0] ADDR_RESULT_HIGH  = 8'h10;
    localparam logic [7:0] ADDR_DIG_IN_OFF   = 8'h14;
    localparam logic [7:0] ADDR_PIN_READ     = 8'h18;

    // =====================================================================
    // field positions
    localparam int REF_SEL_LSB   = 5;
    localparam int LEFT_ADJ_BIT  = 4;
    localparam int CHAN_SEL_LSB  = 0;
    localparam int ENABLE_BIT    = 7;
    localparam int START_BIT     = 6;
    localparam int AUTO_TRIG_BIT = 5;
    localparam int DONE_FLAG_BIT = 4;
    localparam int TRIG_SEL_LSB  = 0;

    // =====================================================================
    // reset values
    localparam logic [7:0] INPUT_SELECT_RST = 8'h00;
    localparam logic [2:0] TRIG_SEL_RST     = 3'h0;
    localparam logic [1:0] DIG_IN_OFF_RST   = 2'h0;

    // =====================================================================
    // codes and timing
    localparam logic [3:0] CHAN_TEMP_SENSOR = 4'hF;
    localparam logic [2:0] TRIG_FREE_RUN    = 3'h0;
    localparam int         CONV_TICKS_NORMAL = 13;
    localparam int         CONV_TICKS_FIRST  = 25;
    localparam int         SYS_CLK_MHZ       = 100;
    localparam int         CONV_CLK_KHZ      = 12500;
    localparam int         PRESCALE_DIV      = (SYS_CLK_MHZ * 1000) / CONV_CLK_KHZ;
    localparam logic [7:0] PRESCALE_LAST     = 8'(PRESCALE_DIV - 1);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_CONV = 3'b100
    } conv_state_t;

endpackage

// *** hw/sar_adc_conversion_control.sv ***
// Overview of operation
// - disabled digital input reads as zero
// - ten-bit code, ground to reference
// - three-bit field selects conversion reference
// - four-bit field selects single or differential
// - differential codes set gain; single bypasses
// - code 1111 selects temperature sensor
// - selections applied only while enabled
// - right aligned result, left when adjusted
// - low read locks result until high read
// - done flag still set when result dropped
// - start bit begins conversion, clears at end; code keeps it set under free running
// - channel change waits for running conversion
// - trigger rising edge resets prescaler, starts
// - no retrigger on level or busy edges
// - flag sets regardless of interrupt enable
// - free running restarts at each completion
// - start works under auto; reads busy
// - result and done flag written together
// - thirteen ticks, twenty-five for first
// - prescaler runs only while enabled
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_conversion_control (
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    // classic wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic             o_wb_ack,
    output logic [31:0]      o_wb_dat,
    // trigger sources, one per trigger_select code; code 0 is free running
    input  wire logic [7:0]  i_trigger_src,
    // comparator pin levels from the port
    input  wire logic [1:0]  i_comp_pin,
    // analog side
    input  wire logic [9:0]  i_analog_code,
    output logic             o_neg_pin_dig_in_off,
    output logic             o_pos_pin_dig_in_off,
    output logic [2:0]       o_reference_select,
    output logic             o_ref_supply,
    output logic             o_ref_ext_pin,
    output logic             o_ref_int_1v1,
    output logic             o_ref_int_2v56,
    output logic             o_single_ended,
    output logic             o_differential,
    output logic             o_temp_sensor,
    output logic [1:0]       o_pos_channel,
    output logic [1:0]       o_neg_channel,
    output logic             o_gain_20x,
    output logic             o_conv_busy
);

    // =====================================================================
    // channel decoding
    // returns {single, diff, temp, gain20, pos[1:0], neg[1:0]}
    function automatic logic [7:0] decode_channel(input logic [3:0] code);
        logic [7:0] r;
        r = 8'h00;
        if (code == conv_ctrl_pkg::CHAN_TEMP_SENSOR) begin
            r = 8'h20;
        end else if (code[3:2] == 2'b00) begin
            r = {1'b1, 3'b000, code[1:0], 2'b00};
        end else if (code[3:2] == 2'b01) begin
            r = {1'b0, 1'b1, 1'b0, code[0], 2'd2, 1'b1, code[1]};
        end else if (code[3:2] == 2'b10) begin
            r = {1'b0, 1'b1, 1'b0, code[0], 2'd0, 1'b0, code[1]};
        end else begin
            r = 8'h00; // reserved codes leave the mux open
        end
        return r;
    endfunction

    // =====================================================================
    // registers and state
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [2:0]  ref_sel_q;
    logic        left_adj_q;
    logic [3:0]  chan_sel_q;
    logic        enable_q;
    logic        start_q;
    logic        auto_trig_q;
    logic        done_flag_q;
    logic [2:0]  trig_sel_q;
    logic [1:0]  dig_off_q;
    logic [9:0]  result_q;
    logic        lock_q;
    logic        first_q;
    logic [7:0]  presc_q;
    logic [7:0]  trig_prev_q;
    logic [2:0]  applied_ref_q;
    logic [3:0]  applied_chan_q;
    conv_ctrl_pkg::conv_state_t state_q;

    logic        bus_req;
    logic        bus_do;
    logic        wr_lane0;
    logic        wr_sel;
    logic        wr_ctrl_a;
    logic        wr_ctrl_b;
    logic        wr_dig_off;
    logic        rd_low;
    logic        rd_high;
    logic        sw_start;
    logic        trig_edge;
    logic        free_run;
    logic        tick;
    logic        core_start;
    logic        core_done;
    logic [9:0]  core_code;
    logic [7:0]  chan_dec;
    logic [15:0] result_word;
    logic [31:0] rdata_d;

    // =====================================================================
    // wishbone slave: ack one cycle after the request, dropped after one
    assign bus_req  = i_wb_cyc && i_wb_stb;
    assign bus_do   = bus_req && ack_q;
    assign wr_lane0 = bus_do && i_wb_we && i_wb_sel[0];
    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdata_q;

    assign wr_sel     = wr_lane0 && (i_wb_adr == conv_ctrl_pkg::ADDR_INPUT_SELECT);
    assign wr_ctrl_a  = wr_lane0 && (i_wb_adr == conv_ctrl_pkg::ADDR_CTRL_A);
    assign wr_ctrl_b  = wr_lane0 && (i_wb_adr == conv_ctrl_pkg::ADDR_CTRL_B);
    assign wr_dig_off = wr_lane0 && (i_wb_adr == conv_ctrl_pkg::ADDR_DIG_IN_OFF);
    assign rd_low  = bus_do && !i_wb_we
                     && (i_wb_adr == conv_ctrl_pkg::ADDR_RESULT_LOW);
    assign rd_high = bus_do && !i_wb_we
                     && (i_wb_adr == conv_ctrl_pkg::ADDR_RESULT_HIGH);

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req && !ack_q;
        end
    end

    // result alignment
    always_comb begin
        if (left_adj_q) begin
            result_word = {result_q, 6'h00};
        end else begin
            result_word = {6'h00, result_q};
        end
    end

    // read data is captured on the request edge so it stands with ack
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (i_wb_adr == conv_ctrl_pkg::ADDR_INPUT_SELECT) begin
            rdata_d[7:0] = {ref_sel_q, left_adj_q, chan_sel_q};
        end else if (i_wb_adr == conv_ctrl_pkg::ADDR_CTRL_A) begin
            rdata_d[conv_ctrl_pkg::ENABLE_BIT]    = enable_q;
            rdata_d[conv_ctrl_pkg::START_BIT]     = start_q || o_conv_busy;
            rdata_d[conv_ctrl_pkg::AUTO_TRIG_BIT] = auto_trig_q;
            rdata_d[conv_ctrl_pkg::DONE_FLAG_BIT] = done_flag_q;
        end else if (i_wb_adr == conv_ctrl_pkg::ADDR_CTRL_B) begin
            rdata_d[2:0] = trig_sel_q;
        end else if (i_wb_adr == conv_ctrl_pkg::ADDR_RESULT_LOW) begin
            rdata_d[7:0] = result_word[7:0];
        end else if (i_wb_adr == conv_ctrl_pkg::ADDR_RESULT_HIGH) begin
            rdata_d[7:0] = result_word[15:8];
        end else if (i_wb_adr == conv_ctrl_pkg::ADDR_DIG_IN_OFF) begin
            rdata_d[1:0] = dig_off_q;
        end else if (i_wb_adr == conv_ctrl_pkg::ADDR_PIN_READ) begin
            rdata_d[1:0] = i_comp_pin & ~dig_off_q;
        end else begin
            rdata_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_req && !ack_q && !i_wb_we) begin
            rdata_q <= rdata_d;
        end
    end

    // =====================================================================
    // software control registers
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ref_sel_q  <= conv_ctrl_pkg::INPUT_SELECT_RST[7:5];
            left_adj_q <= conv_ctrl_pkg::INPUT_SELECT_RST[4];
            chan_sel_q <= conv_ctrl_pkg::INPUT_SELECT_RST[3:0];
        end else if (wr_sel) begin
            ref_sel_q  <= i_wb_dat[conv_ctrl_pkg::REF_SEL_LSB +: 3];
            left_adj_q <= i_wb_dat[conv_ctrl_pkg::LEFT_ADJ_BIT];
            chan_sel_q <= i_wb_dat[conv_ctrl_pkg::CHAN_SEL_LSB +: 4];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            enable_q    <= 1'b0;
            auto_trig_q <= 1'b0;
        end else if (wr_ctrl_a) begin
            enable_q    <= i_wb_dat[conv_ctrl_pkg::ENABLE_BIT];
            auto_trig_q <= i_wb_dat[conv_ctrl_pkg::AUTO_TRIG_BIT];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            trig_sel_q <= conv_ctrl_pkg::TRIG_SEL_RST;
            dig_off_q  <= conv_ctrl_pkg::DIG_IN_OFF_RST;
        end else begin
            if (wr_ctrl_b) begin
                trig_sel_q <= i_wb_dat[conv_ctrl_pkg::TRIG_SEL_LSB +: 3];
            end
            if (wr_dig_off) begin
                dig_off_q <= i_wb_dat[1:0];
            end
        end
    end

    assign o_neg_pin_dig_in_off = dig_off_q[1];
    assign o_pos_pin_dig_in_off = dig_off_q[0];

    // done flag: hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            done_flag_q <= 1'b0;
        end else if (core_done) begin
            done_flag_q <= 1'b1;
        end else if (wr_ctrl_a && i_wb_dat[conv_ctrl_pkg::DONE_FLAG_BIT]) begin
            done_flag_q <= 1'b0;
        end
    end

    // =====================================================================
    // prescaler: held in reset while disabled, restarted by a trigger
    assign tick = enable_q && (presc_q == conv_ctrl_pkg::PRESCALE_LAST);

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            presc_q <= 8'h00;
        end else if (!enable_q) begin
            presc_q <= 8'h00;
        end else if (trig_edge || tick) begin
            presc_q <= 8'h00;
        end else begin
            presc_q <= presc_q + 8'h01;
        end
    end

    // =====================================================================
    // start sources
    assign free_run  = auto_trig_q && (trig_sel_q == conv_ctrl_pkg::TRIG_FREE_RUN);
    assign sw_start  = wr_ctrl_a && i_wb_dat[conv_ctrl_pkg::START_BIT]
                       && i_wb_dat[conv_ctrl_pkg::ENABLE_BIT];

    // edges only; a level still high at completion starts nothing
    assign trig_edge = enable_q && auto_trig_q && !free_run
                       && (state_q == conv_ctrl_pkg::ST_IDLE)
                       && i_trigger_src[trig_sel_q]
                       && !trig_prev_q[trig_sel_q];

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            trig_prev_q <= 8'h00;
        end else begin
            trig_prev_q <= i_trigger_src;
        end
    end

    // =====================================================================
    // conversion sequencer
    assign core_start = ((state_q == conv_ctrl_pkg::ST_WAIT) && tick)
                        || trig_edge
                        || (core_done && free_run && enable_q);

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= conv_ctrl_pkg::ST_IDLE;
        end else if (!enable_q) begin
            state_q <= conv_ctrl_pkg::ST_IDLE;
        end else begin
            case (state_q)
                conv_ctrl_pkg::ST_IDLE: begin
                    if (trig_edge) begin
                        state_q <= conv_ctrl_pkg::ST_CONV;
                    end else if (start_q) begin
                        state_q <= conv_ctrl_pkg::ST_WAIT;
                    end
                end
                conv_ctrl_pkg::ST_WAIT: begin
                    if (tick) begin
                        state_q <= conv_ctrl_pkg::ST_CONV;
                    end
                end
                conv_ctrl_pkg::ST_CONV: begin
                    if (core_done && !core_start) begin
                        state_q <= conv_ctrl_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= conv_ctrl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign o_conv_busy = (state_q == conv_ctrl_pkg::ST_CONV);

    // start bit: a write while busy is absorbed by the running conversion
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            start_q <= 1'b0;
        end else if (!enable_q) begin
            start_q <= 1'b0;
        end else if (sw_start && (state_q == conv_ctrl_pkg::ST_IDLE)) begin
            start_q <= 1'b1;
        end else if (core_done && !free_run) begin
            start_q <= 1'b0;
        end
    end

    // first conversion after enabling runs the long sequence
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            first_q <= 1'b1;
        end else if (!enable_q) begin
            first_q <= 1'b1;
        end else if (core_start) begin
            first_q <= 1'b0;
        end
    end

    // =====================================================================
    // selections pass through only while enabled and not converting
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            applied_ref_q  <= conv_ctrl_pkg::INPUT_SELECT_RST[7:5];
            applied_chan_q <= conv_ctrl_pkg::INPUT_SELECT_RST[3:0];
        end else if (enable_q && !o_conv_busy && !core_start) begin
            applied_ref_q  <= ref_sel_q;
            applied_chan_q <= chan_sel_q;
        end
    end

    assign chan_dec       = decode_channel(applied_chan_q);
    assign o_single_ended = enable_q && chan_dec[7];
    assign o_differential = enable_q && chan_dec[6];
    assign o_temp_sensor  = enable_q && chan_dec[5];
    assign o_gain_20x     = enable_q && chan_dec[4];
    assign o_pos_channel  = chan_dec[3:2];
    assign o_neg_channel  = chan_dec[1:0];

    // reference: 00 supply, 01 external pin, 1x internal (bit 2: 2.56 V)
    assign o_reference_select = applied_ref_q;
    assign o_ref_supply   = enable_q && (applied_ref_q[1:0] == 2'b00);
    assign o_ref_ext_pin  = enable_q && (applied_ref_q[1:0] == 2'b01);
    assign o_ref_int_1v1  = enable_q && applied_ref_q[1] && !applied_ref_q[2];
    assign o_ref_int_2v56 = enable_q && applied_ref_q[1] && applied_ref_q[2];

    // =====================================================================
    // result registers with low-then-high read lock
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lock_q <= 1'b0;
        end else if (rd_high) begin
            lock_q <= 1'b0;
        end else if (rd_low) begin
            lock_q <= 1'b1;
        end
    end

    // a completion during the lock is dropped; the flag still rises
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            result_q <= 10'h000;
        end else if (core_done && !lock_q) begin
            result_q <= core_code;
        end
    end

    // =====================================================================
    // analog core
    sar_core_model u_core (
        .i_sys_clk     (i_sys_clk),
        .i_nrst        (i_nrst),
        .i_tick        (tick),
        .i_start       (core_start),
        .i_first       (first_q),
        .i_analog_code (i_analog_code),
        .o_done        (core_done),
        .o_code        (core_code)
    );

endmodule // sar_adc_conversion_control

`default_nettype wire

// *** hw/sar_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module sar_core_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_tick,
    input  wire logic       i_start,
    input  wire logic       i_first,
    input  wire logic [9:0] i_analog_code,
    output logic            o_done,
    output logic [9:0]      o_code
);

    // =====================================================================
    // conversion length counter, in converter clock ticks
    logic [4:0] ticks_left_q;
    logic       busy_q;
    logic [9:0] held_code_q;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            busy_q       <= 1'b0;
            ticks_left_q <= 5'h00;
        end else if (i_start) begin
            busy_q       <= 1'b1;
            ticks_left_q <= i_first ? 5'(conv_ctrl_pkg::CONV_TICKS_FIRST - 1)
                                    : 5'(conv_ctrl_pkg::CONV_TICKS_NORMAL - 1);
        end else if (busy_q && i_tick) begin
            if (ticks_left_q == 5'h00) begin
                busy_q <= 1'b0;
            end else begin
                ticks_left_q <= ticks_left_q - 5'h01;
            end
        end
    end

    // sample is taken at start; hold keeps it steady through the steps
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            held_code_q <= 10'h000;
        end else if (i_start) begin
            held_code_q <= i_analog_code;
        end
    end

    assign o_done = busy_q && i_tick && (ticks_left_q == 5'h00);
    assign o_code = held_code_q;

endmodule // sar_core_model

`default_nettype wire

// *** testbench/analog_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// analog front end
module analog_src_model (
    input  wire logic       i_single_ended,
    input  wire logic       i_differential,
    input  wire logic       i_temp_sensor,
    input  wire logic       i_gain_20x,
    input  wire logic [1:0] i_pos_channel,
    output logic [9:0]      o_code
);
    // code follows the applied selection, so a result shows its input
    assign o_code = {i_pos_channel, i_temp_sensor, i_gain_20x,
                     i_differential, i_single_ended, 4'h6};
endmodule // analog_src_model
`default_nettype wire

// *** testbench/conv_ctrl_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// conversion control checker
module conv_ctrl_checker (
    input wire logic        i_sys_clk,
    input wire logic        i_nrst,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [7:0]  i_wb_adr,
    input wire logic        o_wb_ack,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_single_ended,
    input wire logic        o_differential,
    input wire logic        o_temp_sensor,
    input wire logic        o_gain_20x,
    input wire logic [1:0]  o_pos_channel,
    input wire logic        o_conv_busy
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    // saturates so a stuck busy cannot wrap back into range
    logic [7:0] busy_len_q;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst)
            busy_len_q <= 8'h00;
        else if (!o_conv_busy)
            busy_len_q <= 8'h00;
        else if (busy_len_q != 8'hFF)
            busy_len_q <= busy_len_q + 8'h01;
    end
    a_ack_prompt: assert property (
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("ack missing after request");
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_temp_alone: assert property (
        o_temp_sensor |-> !o_single_ended && !o_differential && !o_gain_20x)
        else $error("temperature sensor with another input");
    a_gain_diff_only: assert property (
        o_gain_20x |-> o_differential && !o_single_ended)
        else $error("gain set outside a differential pair");
    a_diff_pos_pin: assert property (
        o_differential |-> !o_pos_channel[0] && !o_single_ended)
        else $error("differential positive input not 0 or 2");
    a_chan_frozen: assert property (
        o_conv_busy && $past(o_conv_busy) |-> $stable({o_single_ended,
            o_differential, o_temp_sensor, o_gain_20x, o_pos_channel}))
        else $error("selection changed during conversion");
    a_start_reads_busy: assert property (
        o_wb_ack && !i_wb_we && i_wb_adr == conv_ctrl_pkg::ADDR_CTRL_A
        && o_conv_busy && $past(o_conv_busy)
        |-> o_wb_dat[conv_ctrl_pkg::START_BIT])
        else $error("start bit low while converting");
    a_busy_len: assert property (
        $fell(o_conv_busy) |-> busy_len_q == 8'h68 || busy_len_q == 8'hC8)
        else $error("conversion length out of range");
endmodule // conv_ctrl_checker

bind sar_adc_conversion_control conv_ctrl_checker u_conv_ctrl_checker (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
    .o_single_ended(o_single_ended), .o_differential(o_differential),
    .o_temp_sensor(o_temp_sensor), .o_gain_20x(o_gain_20x),
    .o_pos_channel(o_pos_channel), .o_conv_busy(o_conv_busy));
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// testbench top
module tb_top;
    localparam logic [7:0] A_IS = conv_ctrl_pkg::ADDR_INPUT_SELECT;
    localparam logic [7:0] A_CA = conv_ctrl_pkg::ADDR_CTRL_A;
    localparam logic [7:0] A_CB = conv_ctrl_pkg::ADDR_CTRL_B;
    localparam logic [7:0] A_RL = conv_ctrl_pkg::ADDR_RESULT_LOW;
    localparam logic [7:0] A_RH = conv_ctrl_pkg::ADDR_RESULT_HIGH;
    localparam logic [7:0] A_DO = conv_ctrl_pkg::ADDR_DIG_IN_OFF;
    localparam logic [7:0] A_PR = conv_ctrl_pkg::ADDR_PIN_READ;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [7:0]  trig = 8'h00;
    logic [31:0] rq;
    logic        ack, busy, se, diff, temp, gain, dn, dp;
    logic        r_sup, r_ext, r_1v1, r_256;
    logic [31:0] rdat;
    logic [1:0]  pos, neg;
    logic [2:0]  refsel;
    logic [9:0]  code;
    logic [6:0]  sel_tab [4] = '{7'h03, 7'h15, 7'h2A, 7'h66};
    logic [13:0] exp_tab [4] = '{14'h0113, 14'h0C8E, 14'h1248, 14'h362A};
    int          n_fail = 0;
    int          n_checks = 0;
    always #5 sys_clk = ~sys_clk;
    sar_adc_conversion_control u_sar_adc_conversion_control (
        .i_sys_clk(sys_clk), .i_nrst(nrst), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_ack(ack),
        .o_wb_dat(rdat), .i_trigger_src(trig), .i_comp_pin(2'h3),
        .i_analog_code(code), .o_neg_pin_dig_in_off(dn),
        .o_pos_pin_dig_in_off(dp), .o_reference_select(refsel),
        .o_ref_supply(r_sup), .o_ref_ext_pin(r_ext),
        .o_ref_int_1v1(r_1v1), .o_ref_int_2v56(r_256),
        .o_single_ended(se), .o_differential(diff),
        .o_temp_sensor(temp), .o_pos_channel(pos), .o_neg_channel(neg),
        .o_gain_20x(gain), .o_conv_busy(busy));
    analog_src_model u_analog_src_model (
        .i_single_ended(se), .i_differential(diff),
        .i_temp_sensor(temp), .i_gain_20x(gain),
        .i_pos_channel(pos), .o_code(code));
    // ==========================================
    // tasks
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 20 && ack !== 1'b1; i++)
            @(posedge sys_clk);
        rq = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (i == 20) begin
            check(32'h1, 32'h0);
            test_done();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(rq, exp);
    endtask
    task automatic wait_busy(input logic lvl);
        int i;
        for (i = 0; i < 400 && busy !== lvl; i++)
            @(posedge sys_clk);
        if (i == 400) begin
            n_fail++;
            test_done();
        end
    endtask
    // ==========================================
    // sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(A_IS, 32'h0);
        rd(8'h1C, 32'h0);
        rd(A_PR, 32'h3);
        wb(1'b1, A_DO, 32'h1);
        rd(A_PR, 32'h2);
        check({dn, dp}, 2'h1);
        wb(1'b1, A_IS, 32'hCF);
        repeat (4) @(posedge sys_clk);
        check({temp, r_256}, 2'h0);
        wb(1'b1, A_CA, 32'h80);
        repeat (4) @(posedge sys_clk);
        check({temp, r_256}, 2'h3);
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, A_IS, {24'h0, sel_tab[k][6:4], 1'b0, sel_tab[k][3:0]});
            repeat (4) @(posedge sys_clk);
            check({refsel, neg, r_sup, r_ext, r_1v1, r_256, se, diff, gain,
                   pos}, exp_tab[k]);
        end
        wb(1'b1, A_IS, 32'h03);
        wb(1'b1, A_CA, 32'hC0);
        rd(A_CA, 32'hC0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(A_CA, 32'h90);
        rd(A_RL, 32'h16);
        rd(A_RH, 32'h3);
        wb(1'b1, A_IS, 32'h13);
        wb(1'b1, A_CA, 32'hD0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(A_RL, 32'h80);
        rd(A_RH, 32'hC5);
        wb(1'b1, A_IS, 32'h03);
        wb(1'b1, A_CA, 32'hD0);
        wait_busy(1'b1);
        wb(1'b1, A_IS, 32'h01);
        wait_busy(1'b0);
        repeat (4) @(posedge sys_clk);
        check(pos, 2'h1);
        rd(A_RL, 32'h16);
        rd(A_RH, 32'h3);
        rd(A_RL, 32'h16);
        wb(1'b1, A_CA, 32'hD0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(A_CA, 32'h90);
        rd(A_RH, 32'h3);
        rd(A_RL, 32'h16);
        wb(1'b1, A_CB, 32'h3);
        wb(1'b1, A_CA, 32'hB0);
        trig <= 8'h08;
        wait_busy(1'b1);
        rd(A_CA, 32'hE0);
        trig <= 8'h00;
        @(posedge sys_clk);
        trig <= 8'h08;
        wait_busy(1'b0);
        repeat (40) @(posedge sys_clk);
        check(busy, 1'b0);
        rd(A_CA, 32'hB0);
        wb(1'b1, A_CB, 32'h0);
        wb(1'b1, A_CA, 32'hF0);
        wait_busy(1'b1);
        repeat (300) @(posedge sys_clk);
        check(busy, 1'b1);
        rd(A_CA, 32'hF0);
        test_done();
    end
endmodule // tb_top
`default_nettype wire
